// File: verilog/rfp_pkg.sv
/*
 Package for the fractional prescaler: register offsets, field widths,
 reset values and the tick-rate constants shared by both ends.
 Assumes a single peripheral clock for both ends.
*/
package rfp_pkg;
    localparam int          INT_W          = 13;
    localparam int          FRAC_W         = 15;
    localparam int          REG_W          = 16;
    localparam int          ADDR_W         = 32;
    localparam logic [31:0] INT_VAL_OFFSET  = 32'hE0024080;
    localparam logic [31:0] FRAC_VAL_OFFSET = 32'hE0024084;
    localparam logic [12:0] INT_VAL_RESET   = 13'h0000;
    localparam logic [14:0] FRAC_VAL_RESET  = 15'h0000;
    localparam int          TICK_HZ        = 32768;
    localparam int          MIN_PCLK_HZ    = 65536;
    localparam int          PCLK_HZ        = 10000000;
    localparam logic [12:0] INT_DEFAULT    = 13'((PCLK_HZ / TICK_HZ) - 1);
    localparam logic [14:0] FRAC_DEFAULT   = 15'(PCLK_HZ - (PCLK_HZ / TICK_HZ) * TICK_HZ);
endpackage

// File: verilog/rfp_if.sv
/*
 Interface joining the prescaler with its software-side programmer.
 Assumes both ends share mclk_i and rstn_i.
*/
`timescale 1ns/1ps
interface rfp_if;
    import rfp_pkg::*;
    logic                wr_en;
    logic                rd_en;
    logic [ADDR_W-1:0]   addr;
    logic [REG_W-1:0]    wdata;
    logic [REG_W-1:0]    rdata;
    logic                tick;

    modport dev  (input wr_en, input rd_en, input addr, input wdata, output rdata, output tick);
    modport host (output wr_en, output rd_en, output addr, output wdata, input rdata, input tick);
endinterface

// File: verilog/rfp_prescaler.sv
/*
 Fractional prescaler device end: two registers, 13-bit integer
 down-counter, 15-bit fraction counter, tick output.
 Assumes a register port of simple write/read strobes on mclk_i.
*/
`timescale 1ns/1ps
// Function
// - 13-bit down-counter and 15-bit fraction counter
// - Period is integer plus one, some plus one more
// - Combinational logic decides each period's extension
// - Each fraction bit matches one counter pattern
// - Bit 14 extends periods with counter LSB one
// - Bit 13 extends periods with low bits 10
// - Extended periods spread evenly
// - Zero fraction gives equal periods
// - Integer value bits 12:0, reset zero
// - Fraction value bits 14:0, reset zero
// - Software loads integer value, at least one
// - Software loads fraction as remaining cycles
// - Peripheral clock at least 65.536 kHz
// - Software writes no ones to reserved bits
// - Average 32768 ticks per second
module rfp_prescaler (
    input  wire logic   mclk_i,
    input  wire logic   rstn_i,
    rfp_if.dev          bus,
    output logic [14:0] frac_count_o
);
    import rfp_pkg::*;

    // Register state
    logic [INT_W-1:0]  int_val_q;
    logic [FRAC_W-1:0] frac_val_q;
    logic [REG_W-1:0]  rdata_q;
    logic [REG_W-1:0]  rdata_d;

    // Divider state
    logic [INT_W-1:0]  int_cnt_q;
    logic [INT_W-1:0]  int_cnt_d;
    logic              ext_q;
    logic              ext_d;
    logic [FRAC_W-1:0] frac_cnt_q;
    logic [FRAC_W-1:0] frac_cnt_d;

    // Decode and control
    logic              wr_int;
    logic              wr_frac;
    logic              rd_int;
    logic              rd_frac;
    logic              at_zero;
    logic              extend;
    logic              hold_one;
    logic              period_end;

    // Full-word match keeps aliases out of the two-register map
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] offset);
        return addr == offset;
    endfunction

    // Lowest one of the counter; zero is screened out by the caller
    function automatic logic [3:0] lowest_one(input logic [FRAC_W-1:0] cnt);
        logic [3:0] pos;
        pos = 4'hE;
        for (int p = FRAC_W - 1; p >= 0; p--) begin
            if (cnt[p]) begin
                pos = 4'(p);
            end
        end
        return pos;
    endfunction

    // Bit k of the setting owns counter values whose lowest one is at 14-k;
    // patterns never overlap, so one wrap holds exactly setting extensions
    function automatic logic frac_hit(input logic [FRAC_W-1:0] setting,
                                      input logic [FRAC_W-1:0] cnt);
        logic [3:0] pos;
        pos = lowest_one(cnt);
        if (cnt == 15'h0000) begin
            return 1'b0;
        end
        return setting[4'hE - pos];
    endfunction

    assign wr_int  = bus.wr_en && reg_hit(bus.addr, INT_VAL_OFFSET);
    assign wr_frac = bus.wr_en && reg_hit(bus.addr, FRAC_VAL_OFFSET);
    assign rd_int  = bus.rd_en && reg_hit(bus.addr, INT_VAL_OFFSET);
    assign rd_frac = bus.rd_en && reg_hit(bus.addr, FRAC_VAL_OFFSET);

    // Integer value; a new value only takes effect at the next reload
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            int_val_q <= INT_VAL_RESET;
        end else if (wr_int) begin
            int_val_q <= bus.wdata[INT_W-1:0];
        end
    end

    // Fraction value; takes effect from the next period decision
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frac_val_q <= FRAC_VAL_RESET;
        end else if (wr_frac) begin
            frac_val_q <= bus.wdata[FRAC_W-1:0];
        end
    end

    // Reserved and unmapped bits read as zero, so software sees no noise
    always_comb begin
        rdata_d = rdata_q;
        if (rd_int) begin
            rdata_d = {3'h0, int_val_q};
        end else if (rd_frac) begin
            rdata_d = {1'h0, frac_val_q};
        end else if (bus.rd_en) begin
            rdata_d = 16'h0000;
        end
    end

    // Read data holds until the next read strobe
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign at_zero  = (int_cnt_q == 13'h0000);
    assign extend   = frac_hit(frac_val_q, frac_cnt_q);
    // Counter parks at zero one more clock when the period is stretched
    assign hold_one = at_zero && extend && !ext_q;
    assign period_end = at_zero && !hold_one;

    // Down-count, then either stretch once or reload
    always_comb begin
        int_cnt_d = int_cnt_q;
        if (!at_zero) begin
            int_cnt_d = int_cnt_q - 13'h0001;
        end else if (!hold_one) begin
            int_cnt_d = int_val_q;
        end
    end

    // Stretch marker lives for exactly the one extra clock
    always_comb begin
        ext_d = ext_q;
        if (at_zero) begin
            ext_d = hold_one;
        end
    end

    // Wraps by itself after 32768 periods
    always_comb begin
        frac_cnt_d = frac_cnt_q;
        if (period_end) begin
            frac_cnt_d = frac_cnt_q + 15'h0001;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            int_cnt_q <= INT_VAL_RESET;
        end else begin
            int_cnt_q <= int_cnt_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frac_cnt_q <= 15'h0000;
        end else begin
            frac_cnt_q <= frac_cnt_d;
        end
    end

    // One-cycle tick per period gives 32768 per second when programmed;
    // the tick is combinational so the counter sees it in the same clock
    assign bus.tick     = period_end;
    assign bus.rdata    = rdata_q;
    assign frac_count_o = frac_cnt_q;
endmodule

// File: verilog/rfp_programmer.sv
/*
 Far end: programs both divide values when load_i is seen in idle and counts ticks
 into the clock tick counter.
 Assumes the prescaler end on the same clock and reset.
*/
`timescale 1ns/1ps
module rfp_programmer (
    input  wire logic   mclk_i,
    input  wire logic   rstn_i,
    input  wire logic   [12:0] int_val_i,
    input  wire logic   [14:0] frac_val_i,
    input  wire logic   load_i,
    rfp_if.host         bus,
    output logic [14:0] tick_count_o,
    output logic        loaded_o
);
    import rfp_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_INT, ST_FRAC, ST_RD_INT, ST_RD_FRAC} rfp_state_t;
    rfp_state_t        state_q;
    logic [14:0]       tick_cnt_q;
    logic              loaded_q;
    logic [12:0]       int_safe;

    // Never below one
    assign int_safe = (int_val_i == 13'h0000) ? 13'h0001 : int_val_i;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q  <= ST_IDLE;
            loaded_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (load_i) begin
                        state_q <= ST_INT;
                    end
                end
                ST_INT: begin
                    state_q <= ST_FRAC;
                end
                ST_FRAC: begin
                    state_q <= ST_RD_INT;
                end
                // Read-back lets the bench confirm both values
                ST_RD_INT: begin
                    state_q <= ST_RD_FRAC;
                end
                ST_RD_FRAC: begin
                    state_q  <= ST_IDLE;
                    loaded_q <= 1'b1;
                end
            endcase
        end
    end

    assign bus.wr_en = (state_q == ST_INT) || (state_q == ST_FRAC);
    assign bus.rd_en = (state_q == ST_RD_INT) || (state_q == ST_RD_FRAC);
    assign bus.addr  = ((state_q == ST_FRAC) || (state_q == ST_RD_FRAC)) ? FRAC_VAL_OFFSET : INT_VAL_OFFSET;
    // Reserved bits always written zero
    assign bus.wdata = (state_q == ST_FRAC) ? {1'h0, frac_val_i} : {3'h0, int_safe};

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt_q <= 15'h0000;
        end else if (bus.tick) begin
            tick_cnt_q <= tick_cnt_q + 15'h0001;
        end
    end

    assign tick_count_o = tick_cnt_q;
    assign loaded_o     = loaded_q;
endmodule

// File: sim/rfp_assertions.sv
/* Checker for the prescaler link.
 Assumes the interface signals on mclk_i. */
`timescale 1ns/1ps
module rfp_assertions import rfp_pkg::*; (
    input wire logic              mclk_i,
    input wire logic              rstn_i,
    input wire logic              wr_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [REG_W-1:0]  wdata,
    input wire logic              tick
);
    logic [12:0] int_q, rl_q, gap_q;
    logic [14:0] frac_q;
    wire         wi = wr_en && addr == INT_VAL_OFFSET;
    wire         wf = wr_en && addr == FRAC_VAL_OFFSET;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // Shadow of the registers, same write timing as the device
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            int_q <= '0;
            frac_q <= '0;
        end else begin
            if (wi) int_q <= wdata[12:0];
            if (wf) frac_q <= wdata[14:0];
        end
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_q <= '0;
            rl_q <= '0;
        end else begin
            gap_q <= tick ? '0 : gap_q + 1'b1;
            if (tick) rl_q <= int_q;
        end
    end
    chk_write_order: assert property (wi |=> wf) else $error("fraction write missing");
    chk_write_pulse: assert property (wf |=> !wr_en) else $error("write strobe too long");
    chk_int_reserved: assert property (wi |-> wdata[15:13] == 3'h0) else $error("int reserved set");
    chk_frac_reserved: assert property (wf |-> !wdata[15]) else $error("frac reserved set");
    chk_int_floor: assert property (wi |-> wdata[12:0] != 13'h0000) else $error("int below one");
    chk_period_short: assert property (tick |-> gap_q >= rl_q) else $error("period too short");
    chk_period_long: assert property (gap_q <= rl_q + 1) else $error("period too long");
    chk_frac_zero: assert property (tick && frac_q == 0 |-> gap_q == rl_q) else $error("zero frac stretched");
endmodule

// File: sim/rfp_prescaler_tb.sv
/* Bench joining programmer and prescaler.
 Assumes both ends on mclk_i and rstn_i. */
`timescale 1ns/1ps
module rfp_prescaler_tb;
    import rfp_pkg::*;
    logic        mclk_i = 0, rstn_i = 0, load_i = 0;
    logic [12:0] int_v = 0;
    logic [14:0] frac_v = 0, fc, tc;
    logic [14:0] fco, tco;
    logic        loaded;
    int          n_fail = 0, n_tests = 0, len;
    rfp_if bus ();
    rfp_prescaler i_rfp_prescaler (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus.dev), .frac_count_o(fco));
    rfp_programmer i_rfp_programmer (.mclk_i(mclk_i), .rstn_i(rstn_i), .int_val_i(int_v), .frac_val_i(frac_v),
        .load_i(load_i), .bus(bus.host), .tick_count_o(tco), .loaded_o(loaded));
    rfp_assertions i_rfp_assertions (.mclk_i(mclk_i), .rstn_i(rstn_i), .wr_en(bus.wr_en), .addr(bus.addr),
        .wdata(bus.wdata), .tick(bus.tick));
    // 10 MHz, well above the minimum peripheral clock
    always #50 mclk_i = ~mclk_i;
    task chk(string what, logic [15:0] exp, logic [15:0] seen);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] ext(logic [14:0] f, logic [14:0] c);
        for (int p = 0; p < 15; p++) if (c[p]) return {15'h0000, f[14-p]};
        return 16'h0000;
    endfunction
    // Cycles from one tick to the next, bounded against a hang
    task automatic gap(output int n);
        n = 1;
        @(negedge mclk_i);
        while (bus.tick !== 1'b1 && n < 99) begin
            n++;
            @(negedge mclk_i);
        end
    endtask
    task automatic run(logic [12:0] iv, logic [14:0] fv, logic [12:0] ev, string nm);
        int_v = iv;
        frac_v = fv;
        load_i = 1;
        @(negedge mclk_i);
        load_i = 0;
        // Writes land two edges on, read-back data one edge later each
        repeat (3) @(negedge mclk_i);
        chk("int readback", {3'h0, ev}, bus.rdata);
        @(negedge mclk_i);
        chk("frac readback", {1'h0, fv}, bus.rdata);
        chk("loaded", 16'h0001, {15'h0000, loaded});
        // New values only land at a reload
        repeat (4) gap(len);
        repeat (8) begin
            fc = fco + 1'b1;
            tc = tco;
            gap(len);
            chk("period", ev + 1 + ext(fv, fc), len[15:0]);
            chk("frac count", fc, fco);
            chk("tick count", tc + 1'b1, tco);
        end
        $display("test %s done", nm);
    endtask
    task report_and_stop();
        $display("compares %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(negedge mclk_i);
        rstn_i = 1;
        repeat (3) begin
            gap(len);
            chk("reset period", 16'h0001, len[15:0]);
        end
        $display("test reset done");
        run(13'h0001, 15'h0000, 13'h0001, "equal");
        run(13'h0001, 15'h4000, 13'h0001, "half");
        run(13'h0001, 15'h2000, 13'h0001, "quarter");
        run(13'h0000, 15'h2000, 13'h0001, "clamp");
        run(13'h0002, 15'h6001, 13'h0002, "mixed");
        report_and_stop();
    end
endmodule
